//--- hw/srw_pkg.sv
// Package of constants and types for the supervisor reset watchdog
package srw_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_HZ            = 40_000_000;
  localparam int unsigned RESET_HOLD_US     = 2000;
  localparam int unsigned RESET_REACT_US    = 10;
  localparam int unsigned WD_LONG_MS        = 200;
  localparam int unsigned WD_SHORT_MS       = 100;
  localparam int unsigned RESET_HOLD_CYC    = RESET_HOLD_US * (CLK_HZ / 1_000_000);
  localparam int unsigned RESET_REACT_CYC   = RESET_REACT_US * (CLK_HZ / 1_000_000);
  localparam int unsigned WD_LONG_CYC       = WD_LONG_MS * (CLK_HZ / 1000);
  localparam int unsigned WD_SHORT_CYC      = WD_SHORT_MS * (CLK_HZ / 1000);
  localparam int unsigned MAX_TIMEOUTS      = 3;
  // Synchroniser values after reset: fallback select and sense reference idle high
  localparam logic [12:0] SYNC_IDLE_VAL     = 13'h0201;

  // ****************************************************************
  // Register map (byte addresses)
  // ****************************************************************
  localparam logic [7:0] ADDR_CONTROL       = 8'h00;
  localparam logic [7:0] ADDR_GLOBAL_STATUS = 8'h04;
  localparam logic [7:0] ADDR_STATUS_ONE    = 8'h08;

  // Control fields
  localparam int unsigned CTL_WD_TRIGGER    = 0;
  localparam int unsigned CTL_WD_SHORT      = 1;
  localparam int unsigned CTL_SW_FALLBACK   = 2;
  localparam logic [2:0]  CTL_RESET_VAL     = 3'h0;

  // Global status byte fields
  localparam int unsigned GSB_LED_OV        = 7;
  localparam int unsigned GSB_FALLBACK      = 0;

  // Status one fields
  localparam int unsigned SR1_WD_FAIL       = 0;
  localparam int unsigned SR1_BAT_OV        = 1;
  localparam int unsigned SR1_OVER_TEMP     = 2;
  localparam int unsigned SR1_REG_OFF       = 3;
  localparam int unsigned SR1_LED_OV        = 18;

  typedef enum logic [2:0] {
    SRW_POWERUP = 3'b000,
    SRW_HOLD    = 3'b001,
    SRW_RUN     = 3'b010,
    SRW_PULSE   = 3'b011,
    SRW_REACT   = 3'b100
  } srw_state_t;

endpackage : srw_pkg

//--- hw/srw_top.sv
// Supervisor: host reset, watchdog, limp home and fault shutdown
//
// Notes on behaviour
// [R1] Reset low while regulator below threshold
// [R2] Hold reset low fixed delay after threshold
// [R3] Undervoltage or standby: delayed reset assertion
// [R4] Reset pin only pulls down
// [R5] Periodic reset pulses until host acknowledges
// [R6] Watchdog window selectable, long default
// [R7] Refresh only on trigger bit toggle
// [R8] First timeout: reset pulse, limp home
// [R9] Second timeout: another pulse, keep waiting
// [R10] Three timeouts: main regulator off
// [R11] Failure: fallback pin decides converter state
// [R12] Reset tied to battery: no watchdog
// [R13] LED overvoltage forces both gates low
// [R14] LED overvoltage closes discharge switch
// [R15] LED overvoltage sets status bits 7, 18
// [R16] Battery overvoltage stops until release
// [R17] Sense reference select defaults high
// [R18] Overtemperature kills both regulators, retries
// [R19] Limp home resets controls except fallback
// [R20] Clear status one plus trigger exits limp
// [R21] Refresh clears consecutive timeout counter
// [R22] Counters and latches cleared at reset
`timescale 1ns/100ps

module srw_top
  import srw_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        main_reg_good,
  input  wire logic        standby_req,
  input  wire logic        reset_pin_at_battery,
  input  wire logic        fallback_select_pin,
  input  wire logic        dim_pwm_in,
  input  wire logic        gate_main_req,
  input  wire logic        led_ov_upper_trip,
  input  wire logic        led_ov_lower_clear,
  input  wire logic        battery_ov_sense,
  input  wire logic        battery_ov_release,
  input  wire logic        reg_two_over_temp,
  input  wire logic        reg_two_temp_ok,
  input  wire logic        sense_reference_select,
  output logic             host_reset_out_n,
  output logic             host_reset_oe,
  output logic             gate_drive_main,
  output logic             gate_drive_dimming,
  output logic             discharge_switch,
  output logic             main_regulator_enable,
  output logic             aux_regulator_enable,
  output logic             battery_referenced_sense
);

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  localparam int unsigned NSYNC = 13;
  logic [NSYNC-1:0] sync_a_q;
  logic [NSYNC-1:0] sync_b_q;
  logic [NSYNC-1:0] raw_in;
  assign raw_in = {main_reg_good, standby_req, reset_pin_at_battery, fallback_select_pin,
                   dim_pwm_in, gate_main_req, led_ov_upper_trip, led_ov_lower_clear,
                   battery_ov_sense, battery_ov_release, reg_two_over_temp,
                   reg_two_temp_ok, sense_reference_select};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sync_a_q[gi] <= SYNC_IDLE_VAL[gi];
          sync_b_q[gi] <= SYNC_IDLE_VAL[gi];
        end else begin
          sync_a_q[gi] <= raw_in[gi];
          sync_b_q[gi] <= sync_a_q[gi];
        end
      end
    end
  endgenerate

  logic s_good, s_stby, s_alone, s_fb, s_dim, s_gate, s_ledov, s_ledclr;
  logic s_bov, s_brel, s_ot, s_tok, s_ref;
  assign {s_good, s_stby, s_alone, s_fb, s_dim, s_gate, s_ledov, s_ledclr,
          s_bov, s_brel, s_ot, s_tok, s_ref} = sync_b_q;

  // ****************************************************************
  // APB slave
  // ****************************************************************
  logic       acc_wr;
  logic       acc_rd;
  logic       sr1_read_clear;
  logic       trig_q;
  logic       wd_short_q;
  logic       sw_fb_q;
  logic       toggle_seen;
  logic [2:0] timeouts_q;
  logic       limp_q;
  logic       reg_off_q;
  logic       led_ov_q;
  logic       wd_fail_q;
  logic       bat_ov_q;
  logic       ot_q;
  logic       limp_enter;

  assign pready         = 1'b1;
  assign acc_wr         = psel && penable && pwrite;
  assign acc_rd         = psel && penable && !pwrite;
  assign sr1_read_clear = acc_rd && (paddr == ADDR_STATUS_ONE);

  always_comb begin
    pslverr = 1'b0;
    if (psel && penable && !(paddr == ADDR_CONTROL || paddr == ADDR_GLOBAL_STATUS ||
        paddr == ADDR_STATUS_ONE)) begin
      pslverr = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= 32'h0;
      case (paddr)
        ADDR_CONTROL: begin
          prdata[CTL_WD_TRIGGER]  <= trig_q;
          prdata[CTL_WD_SHORT]    <= wd_short_q;
          prdata[CTL_SW_FALLBACK] <= sw_fb_q;
        end
        ADDR_GLOBAL_STATUS: begin
          prdata[GSB_LED_OV]   <= led_ov_q;
          prdata[GSB_FALLBACK] <= limp_q;
        end
        ADDR_STATUS_ONE: begin
          prdata[SR1_WD_FAIL]   <= wd_fail_q;
          prdata[SR1_BAT_OV]    <= bat_ov_q;
          prdata[SR1_OVER_TEMP] <= ot_q;
          prdata[SR1_REG_OFF]   <= reg_off_q;
          prdata[SR1_LED_OV]    <= led_ov_q;
        end
        default: begin
          prdata <= 32'h0;
        end
      endcase
    end
  end

  assign toggle_seen = acc_wr && (paddr == ADDR_CONTROL) && (pwdata[CTL_WD_TRIGGER] != trig_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_q     <= CTL_RESET_VAL[CTL_WD_TRIGGER];
      wd_short_q <= CTL_RESET_VAL[CTL_WD_SHORT];
      sw_fb_q    <= CTL_RESET_VAL[CTL_SW_FALLBACK];
    // [R19] Defaults on limp entry
    end else if (limp_enter) begin
      trig_q     <= CTL_RESET_VAL[CTL_WD_TRIGGER];
      wd_short_q <= CTL_RESET_VAL[CTL_WD_SHORT];
    end else if (acc_wr && paddr == ADDR_CONTROL) begin
      trig_q     <= pwdata[CTL_WD_TRIGGER];
      wd_short_q <= pwdata[CTL_WD_SHORT];
      sw_fb_q    <= pwdata[CTL_SW_FALLBACK];
    end
  end

  // ****************************************************************
  // Reset and watchdog sequencer
  // ****************************************************************
  srw_state_t  state_q;
  logic [31:0] cnt_q;
  logic [31:0] wd_limit;
  logic        acked_q;
  logic        standalone_q;

  // [R6] Long window unless short selected
  assign wd_limit = wd_short_q ? WD_SHORT_CYC : WD_LONG_CYC;
  assign limp_enter = (state_q == SRW_RUN) && acked_q && !standalone_q &&
                      (cnt_q >= wd_limit - 1) && !toggle_seen;

  // [R12] Strap caught after reset release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      standalone_q <= 1'b0;
    end else if (state_q == SRW_POWERUP) begin
      standalone_q <= s_alone;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    // [R22] Counters cleared on reset
    if (!presetn) begin
      state_q    <= SRW_POWERUP;
      cnt_q      <= 32'h0;
      acked_q    <= 1'b0;
      timeouts_q <= 3'h0;
    end else begin
      if (toggle_seen) begin
        acked_q <= 1'b1;
        // [R21] Refresh restarts escalation
        timeouts_q <= 3'h0;
      end
      case (state_q)
        // [R1] Held while regulator low
        SRW_POWERUP: begin
          cnt_q <= 32'h0;
          if (s_good && !s_stby) begin
            state_q <= SRW_HOLD;
          end
        end
        // [R2] Fixed hold before release
        SRW_HOLD, SRW_PULSE: begin
          if (!s_good) begin
            state_q <= SRW_POWERUP;
          end else if (cnt_q >= RESET_HOLD_CYC - 1) begin
            cnt_q   <= 32'h0;
            state_q <= SRW_RUN;
          end else begin
            cnt_q <= cnt_q + 32'h1;
          end
        end
        SRW_RUN: begin
          if (!s_good || s_stby) begin
            cnt_q   <= 32'h0;
            state_q <= SRW_REACT;
          end else if (toggle_seen || standalone_q || reg_off_q) begin
            // [R7] A toggle restarts the window; standalone or regulator off holds it at zero
            cnt_q <= 32'h0;
          end else if (cnt_q >= wd_limit - 1) begin
            // [R5] [R8] [R9] Pulse on each timeout
            cnt_q   <= 32'h0;
            state_q <= SRW_PULSE;
            if (acked_q && timeouts_q < 3'(MAX_TIMEOUTS)) begin
              timeouts_q <= timeouts_q + 3'h1;
            end
          end else begin
            cnt_q <= cnt_q + 32'h1;
          end
        end
        // [R3] Delayed assertion on undervoltage
        SRW_REACT: begin
          if (s_good && !s_stby) begin
            cnt_q   <= 32'h0;
            state_q <= SRW_RUN;
          end else if (cnt_q >= RESET_REACT_CYC - 1) begin
            state_q <= SRW_POWERUP;
          end else begin
            cnt_q <= cnt_q + 32'h1;
          end
        end
        default: begin
          state_q <= SRW_POWERUP;
        end
      endcase
    end
  end

  // [R8] [R20] Limp home entry and exit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      limp_q    <= 1'b0;
      reg_off_q <= 1'b0;
    end else begin
      if (limp_enter) begin
        limp_q <= 1'b1;
      end else if (toggle_seen && !wd_fail_q && !reg_off_q) begin
        limp_q <= 1'b0;
      end
      // [R10] Third timeout turns regulator off
      if (state_q == SRW_RUN && !toggle_seen && cnt_q >= wd_limit - 1 && acked_q &&
          timeouts_q == 3'(MAX_TIMEOUTS - 1)) begin
        reg_off_q <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Fault latches
  // ****************************************************************
  logic bat_stop_q;
  logic ot_stop_q;
  logic disch_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      led_ov_q   <= 1'b0;
      wd_fail_q  <= 1'b0;
      bat_ov_q   <= 1'b0;
      ot_q       <= 1'b0;
      bat_stop_q <= 1'b0;
      ot_stop_q  <= 1'b0;
      disch_q    <= 1'b0;
    end else begin
      // [R15] Status set wins over read clear
      if (s_ledov && !bat_stop_q) begin
        led_ov_q <= 1'b1;
      end else if (sr1_read_clear) begin
        led_ov_q <= 1'b0;
      end
      if (limp_enter) begin
        wd_fail_q <= 1'b1;
      end else if (sr1_read_clear) begin
        wd_fail_q <= 1'b0;
      end
      if (s_bov) begin
        bat_ov_q <= 1'b1;
      end else if (sr1_read_clear) begin
        bat_ov_q <= 1'b0;
      end
      if (s_ot) begin
        ot_q <= 1'b1;
      end else if (sr1_read_clear) begin
        ot_q <= 1'b0;
      end
      // [R16] Stop until release comparator
      if (s_bov) begin
        bat_stop_q <= 1'b1;
      end else if (s_brel) begin
        bat_stop_q <= 1'b0;
      end
      // [R18] Overtemperature off until cool
      if (s_ot) begin
        ot_stop_q <= 1'b1;
      end else if (s_tok) begin
        ot_stop_q <= 1'b0;
      end
      // [R14] Discharge after LED overvoltage
      if (s_ledov && !bat_stop_q) begin
        disch_q <= 1'b1;
      end else if (s_ledclr) begin
        disch_q <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  logic stop_all;
  logic conv_on;
  logic fail_mode;

  // [R13] LED overvoltage blocks gates
  assign stop_all  = led_ov_q || s_ledov || s_bov || bat_stop_q || ot_stop_q || limp_q && !s_fb;
  assign fail_mode = limp_q || sw_fb_q;

  // [R11] Fallback pin overrides dimming
  always_comb begin
    conv_on = 1'b0;
    if (!stop_all) begin
      conv_on = fail_mode ? s_fb : s_dim;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_reset_oe            <= 1'b1;
      gate_drive_main          <= 1'b0;
      gate_drive_dimming       <= 1'b0;
      discharge_switch         <= 1'b0;
      main_regulator_enable    <= 1'b0;
      aux_regulator_enable     <= 1'b0;
      battery_referenced_sense <= 1'b1;
    end else begin
      // [R4] [R12] Drive low only, never high
      host_reset_oe            <= !standalone_q && (state_q == SRW_POWERUP ||
                                  state_q == SRW_HOLD || state_q == SRW_PULSE);
      gate_drive_main          <= conv_on && s_gate;
      gate_drive_dimming       <= conv_on;
      discharge_switch         <= disch_q;
      // [R18] Off at once when hot
      main_regulator_enable    <= !ot_stop_q && !s_ot && !reg_off_q;
      aux_regulator_enable     <= !ot_stop_q && !s_ot;
      // [R17] High selects battery reference
      battery_referenced_sense <= s_ref;
    end
  end

  assign host_reset_out_n = 1'b0;

endmodule : srw_top

//--- verif/srw_assertions.sv
// Checker of port timing for the supervisor reset watchdog
`timescale 1ns/100ps

module srw_checker
  import srw_pkg::*;
(
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic [7:0] paddr,
  input wire logic       pslverr,
  input wire logic       main_reg_good,
  input wire logic       reset_pin_at_battery,
  input wire logic       led_ov_upper_trip,
  input wire logic       led_ov_lower_clear,
  input wire logic       battery_ov_sense,
  input wire logic       reg_two_over_temp,
  input wire logic       sense_reference_select,
  input wire logic       host_reset_out_n,
  input wire logic       host_reset_oe,
  input wire logic       gate_drive_main,
  input wire logic       gate_drive_dimming,
  input wire logic       discharge_switch,
  input wire logic       main_regulator_enable,
  input wire logic       aux_regulator_enable,
  input wire logic       battery_referenced_sense
);
  localparam int unsigned HOLD_LO = RESET_HOLD_CYC - 4;
  localparam int unsigned HOLD_HI = RESET_HOLD_CYC + 8;
  logic [31:0] hold_q;
  logic        mapped;

  assign mapped = (paddr == ADDR_CONTROL) || (paddr == ADDR_GLOBAL_STATUS)
                  || (paddr == ADDR_STATUS_ONE);

  // Cycles of reset held while the regulator is good
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_q <= 32'h0;
    end else begin
      hold_q <= (main_reg_good && host_reset_oe) ? hold_q + 32'h1 : 32'h0;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_reset_pull_only: assert property (host_reset_out_n == 1'b0)
    else $error("reset pin driven high");
  a_hold_length: assert property ($fell(host_reset_oe) && !reset_pin_at_battery
    |-> hold_q >= HOLD_LO && hold_q <= HOLD_HI) else $error("reset hold length wrong");
  a_reset_held_low: assert property ((!main_reg_good)[*4] ##0 host_reset_oe
    |=> host_reset_oe) else $error("reset released while regulator low");
  a_ledov_gates: assert property (led_ov_upper_trip[*4]
    |-> !gate_drive_main && !gate_drive_dimming) else $error("gates on in LED overvoltage");
  a_ledov_discharge: assert property ((led_ov_upper_trip && !led_ov_lower_clear
    && !battery_ov_sense)[*5] |-> discharge_switch) else $error("discharge switch open");
  a_batov_gates: assert property (battery_ov_sense[*4]
    |-> !gate_drive_main && !gate_drive_dimming) else $error("gates on in battery overvoltage");
  a_temp_regs_off: assert property (reg_two_over_temp[*4]
    |-> !main_regulator_enable && !aux_regulator_enable) else $error("regulator on when hot");
  a_sense_high: assert property (sense_reference_select[*4]
    |-> battery_referenced_sense) else $error("sense reference not battery");
  a_sense_low: assert property ((!sense_reference_select)[*4]
    |-> !battery_referenced_sense) else $error("sense reference not ground");
  a_slverr_map: assert property (psel && penable |-> pslverr == !mapped)
    else $error("slave error does not match address map");
endmodule // srw_checker

bind srw_top srw_checker u_chk (.pclk, .presetn, .psel, .penable, .paddr, .pslverr,
  .main_reg_good, .reset_pin_at_battery, .led_ov_upper_trip, .led_ov_lower_clear,
  .battery_ov_sense, .reg_two_over_temp, .sense_reference_select, .host_reset_out_n,
  .host_reset_oe, .gate_drive_main, .gate_drive_dimming, .discharge_switch,
  .main_regulator_enable, .aux_regulator_enable, .battery_referenced_sense);

//--- verif/srw_host_model.sv
// Host side of the reset line with its external pull-up
`timescale 1ns/100ps

module srw_host_model (
  input  wire logic host_reset_out_n,
  input  wire logic host_reset_oe,
  output logic      reset_line
);
  assign reset_line = host_reset_oe ? host_reset_out_n : 1'b1;
endmodule // srw_host_model

//--- verif/tb.sv
// Self-checking bench for the supervisor reset watchdog
`timescale 1ns/100ps

module tb;
  import srw_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        main_reg_good, standby_req, reset_pin_at_battery, fallback_select_pin;
  logic        dim_pwm_in, gate_main_req, led_ov_upper_trip, led_ov_lower_clear;
  logic        battery_ov_sense, battery_ov_release, reg_two_over_temp, reg_two_temp_ok;
  logic        sense_reference_select, host_reset_out_n, host_reset_oe, gate_drive_main;
  logic        gate_drive_dimming, discharge_switch, main_regulator_enable;
  logic        aux_regulator_enable, battery_referenced_sense, reset_line;
  int          fail_count, n_compared;

  srw_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .main_reg_good, .standby_req, .reset_pin_at_battery,
    .fallback_select_pin, .dim_pwm_in, .gate_main_req, .led_ov_upper_trip,
    .led_ov_lower_clear, .battery_ov_sense, .battery_ov_release, .reg_two_over_temp,
    .reg_two_temp_ok, .sense_reference_select, .host_reset_out_n, .host_reset_oe,
    .gate_drive_main, .gate_drive_dimming, .discharge_switch, .main_regulator_enable,
    .aux_regulator_enable, .battery_referenced_sense);
  srw_host_model host (.host_reset_out_n, .host_reset_oe, .reset_line);

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test();
    if (fail_count == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) fail_count++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic t_power();
    int n;
    cyc(20);
    check("reset pin low", reset_line, 1'b0);
    main_reg_good <= 1'b1;
    n = 0;
    while (reset_line !== 1'b1 && n < RESET_HOLD_CYC + 100) begin
      cyc(1);
      n++;
    end
    check("reset hold", n >= RESET_HOLD_CYC && n <= RESET_HOLD_CYC + 8, 1'b1);
  endtask

  task automatic t_regs();
    apb(1'b0, ADDR_CONTROL, 32'h0);
    check("control reset", rd, 32'h0);
    apb(1'b1, ADDR_CONTROL, 32'h00000007);
    apb(1'b0, ADDR_CONTROL, 32'h0);
    check("control rw", rd, 32'h00000007);
    apb(1'b0, 8'h0c, 32'h0);
    check("unmapped err", err, 1'b1);
    check("unmapped data", rd, 32'h0);
    apb(1'b1, ADDR_STATUS_ONE, 32'hffffffff);
    apb(1'b0, ADDR_STATUS_ONE, 32'h0);
    check("status one clear", rd, 32'h0);
    apb(1'b1, ADDR_CONTROL, 32'h00000006);
    apb(1'b0, ADDR_GLOBAL_STATUS, 32'h0);
    check("limp flag clear", rd[GSB_FALLBACK], 1'b0);
  endtask

  task automatic t_faults();
    gate_main_req <= 1'b1;
    dim_pwm_in <= 1'b1;
    cyc(6);
    check("gate on", gate_drive_main, 1'b1);
    led_ov_upper_trip <= 1'b1;
    cyc(5);
    check("ledov gate main", gate_drive_main, 1'b0);
    check("ledov gate dim", gate_drive_dimming, 1'b0);
    check("discharge on", discharge_switch, 1'b1);
    led_ov_upper_trip <= 1'b0;
    led_ov_lower_clear <= 1'b1;
    cyc(6);
    check("discharge off", discharge_switch, 1'b0);
    apb(1'b0, ADDR_GLOBAL_STATUS, 32'h0);
    check("status byte ledov", rd[GSB_LED_OV], 1'b1);
    apb(1'b0, ADDR_STATUS_ONE, 32'h0);
    check("status one ledov", rd[SR1_LED_OV], 1'b1);
    led_ov_lower_clear <= 1'b0;
    battery_ov_sense <= 1'b1;
    cyc(5);
    check("batov gate", gate_drive_main, 1'b0);
    battery_ov_sense <= 1'b0;
    cyc(10);
    check("batov wait", gate_drive_main, 1'b0);
    battery_ov_release <= 1'b1;
    cyc(6);
    check("batov restart", gate_drive_main, 1'b1);
    battery_ov_release <= 1'b0;
    reg_two_over_temp <= 1'b1;
    cyc(5);
    check("hot main off", main_regulator_enable, 1'b0);
    check("hot aux off", aux_regulator_enable, 1'b0);
    reg_two_over_temp <= 1'b0;
    reg_two_temp_ok <= 1'b1;
    cyc(6);
    check("cool main on", main_regulator_enable, 1'b1);
    check("cool aux on", aux_regulator_enable, 1'b1);
  endtask

  task automatic t_misc();
    for (int v = 0; v < 2; v++) begin
      sense_reference_select <= v[0];
      cyc(5);
      check("sense ref", battery_referenced_sense, v[0]);
    end
    // Software fallback is still requested, so the pin decides the converter
    dim_pwm_in <= 1'b0;
    cyc(6);
    check("fallback on", gate_drive_dimming, 1'b1);
    fallback_select_pin <= 1'b0;
    cyc(6);
    check("fallback off", gate_drive_dimming, 1'b0);
    standby_req <= 1'b1;
    cyc(RESET_REACT_CYC - 5);
    check("standby delay", reset_line, 1'b1);
    cyc(15);
    check("standby reset", reset_line, 1'b0);
  endtask

  task automatic t_alone();
    presetn <= 1'b0;
    reset_pin_at_battery <= 1'b1;
    cyc(6);
    presetn <= 1'b1;
    cyc(10);
    check("standalone reset", reset_line, 1'b1);
  endtask

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  initial begin
    #2_500_000;
    fail_count++;
    finish_test();
  end

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {main_reg_good, standby_req, reset_pin_at_battery, dim_pwm_in, gate_main_req} = '0;
    {led_ov_upper_trip, led_ov_lower_clear, battery_ov_sense, battery_ov_release} = '0;
    {reg_two_over_temp, reg_two_temp_ok} = '0;
    fallback_select_pin = 1'b1;
    sense_reference_select = 1'b1;
    fail_count = 0;
    n_compared = 0;
    cyc(6);
    presetn <= 1'b1;
    t_power();
    t_regs();
    t_faults();
    t_misc();
    t_alone();
    finish_test();
  end
endmodule // tb
